// file: design/lst_top.sv
`timescale 1ns/10ps
module lst_top #(
	parameter int OSC_DIV_P   = lst_pkg::OSC_DIV,       // System clocks per osc tick
	parameter int STEP_CLKS_P = lst_pkg::STEP_INT_CLKS, // Integration clocks per step
	parameter logic [6:0] DEV_ADDR_P = lst_pkg::DEV_ADDR_DEF // Bus address
) (
	input  wire logic                clk_i,      // 250 MHz clock
	input  wire logic                rst_i,      // Async reset, high
	input  wire logic                scl_i,      // Serial clock pin
	input  wire logic                sda_i,      // Serial data pin level
	output logic                     sda_o,      // Serial data drive value
	output logic                     sda_oe_o,   // Serial data drive enable
	output lst_pkg::lst_status_t     status_o,   // Sequencer status
	output logic [15:0]              max_count_o // Full-scale channel count
);

	// Wide enough for 256 steps times 1024 without wrapping
	function automatic logic [15:0] full_scale(input logic [7:0] steps);
		logic [18:0] v;
		v = ({11'h000, steps} + 19'h00001) * {2'h0, lst_pkg::COUNT_PER_STEP} - 19'h00001;
		if (v > {2'h0, lst_pkg::COUNT_SAT})
			v = {2'h0, lst_pkg::COUNT_SAT};
		return v[15:0];
	endfunction

	// Pin synchronisers
	logic [1:0] scl_sync_q, sda_sync_q;
	logic       scl_prev_q, sda_prev_q;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_s     = scl_sync_q[1];
	assign sda_s     = sda_sync_q[1];
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// Registers
	logic [7:0] func_en_q, integ_q, wait_q, cfg0_q;
	logic [7:0] ptr_q, shift_q, tx_q, rd_data;
	logic [3:0] bit_cnt_q;
	logic       ack_drive_q, read_nack_q, wr_stb;
	lst_pkg::lst_bus_t bus_q;

	always_comb
	begin
		unique case (ptr_q)
			lst_pkg::FUNC_EN_ADDR: rd_data = func_en_q;
			lst_pkg::INTEG_ADDR:   rd_data = integ_q;
			lst_pkg::WAIT_ADDR:    rd_data = wait_q;
			lst_pkg::CFG0_ADDR:    rd_data = cfg0_q;
			default:               rd_data = lst_pkg::RD_UNMAPPED;
		endcase
	end

	assign wr_stb = scl_fall & (bus_q == lst_pkg::BUS_WDATA) & (bit_cnt_q == lst_pkg::LAST_BIT);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			func_en_q <= lst_pkg::FUNC_EN_RST;
			integ_q   <= lst_pkg::INTEG_RST;
			wait_q    <= lst_pkg::WAIT_RST;
			cfg0_q    <= lst_pkg::CFG0_RST;
		end
		else if (wr_stb)
		begin
			unique case (ptr_q)
				lst_pkg::FUNC_EN_ADDR: func_en_q <= shift_q;
				lst_pkg::INTEG_ADDR:   integ_q   <= shift_q;
				lst_pkg::WAIT_ADDR:    wait_q    <= shift_q;
				lst_pkg::CFG0_ADDR:    cfg0_q    <= shift_q;
				default:               ;
			endcase
		end
	end

	// Serial byte engine with auto-incrementing pointer
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bus_q       <= lst_pkg::BUS_IDLE;
			bit_cnt_q   <= 4'h0;
			shift_q     <= 8'h00;
			tx_q        <= 8'h00;
			ptr_q       <= 8'h00;
			ack_drive_q <= 1'b0;
			read_nack_q <= 1'b0;
		end
		else if (bus_start)
		begin
			bus_q       <= lst_pkg::BUS_DEV;
			bit_cnt_q   <= '1; // Wraps to zero on the fall after start
			ack_drive_q <= 1'b0;
		end
		else if (bus_stop)
		begin
			bus_q       <= lst_pkg::BUS_IDLE;
			ack_drive_q <= 1'b0;
		end
		else if (scl_rise && bus_q != lst_pkg::BUS_IDLE)
		begin
			if (bit_cnt_q != lst_pkg::ACK_SLOT)
				shift_q <= {shift_q[6:0], sda_s};
			else
				read_nack_q <= sda_s;
		end
		else if (scl_fall && bus_q != lst_pkg::BUS_IDLE)
		begin
			if (bit_cnt_q == lst_pkg::LAST_BIT)
			begin
				bit_cnt_q <= lst_pkg::ACK_SLOT;
				unique case (bus_q)
					lst_pkg::BUS_DEV:
					begin
						if (shift_q[7:1] == DEV_ADDR_P)
							ack_drive_q <= 1'b1;
						else
							bus_q <= lst_pkg::BUS_IDLE;
					end
					lst_pkg::BUS_REG:
					begin
						ptr_q       <= shift_q;
						ack_drive_q <= 1'b1;
					end
					lst_pkg::BUS_WDATA:
					begin
						ptr_q       <= ptr_q + lst_pkg::PTR_STEP;
						ack_drive_q <= 1'b1;
					end
					default: ;
				endcase
			end
			else if (bit_cnt_q == lst_pkg::ACK_SLOT)
			begin
				bit_cnt_q   <= 4'h0;
				ack_drive_q <= 1'b0;
				unique case (bus_q)
					lst_pkg::BUS_DEV:
					begin
						if (shift_q[0])
						begin
							bus_q <= lst_pkg::BUS_RDATA;
							tx_q  <= rd_data;
							ptr_q <= ptr_q + lst_pkg::PTR_STEP;
						end
						else
							bus_q <= lst_pkg::BUS_REG;
					end
					lst_pkg::BUS_REG: bus_q <= lst_pkg::BUS_WDATA;
					lst_pkg::BUS_RDATA:
					begin
						if (read_nack_q)
							bus_q <= lst_pkg::BUS_IDLE;
						else
						begin
							tx_q  <= rd_data;
							ptr_q <= ptr_q + lst_pkg::PTR_STEP;
						end
					end
					default: ;
				endcase
			end
			else
			begin
				bit_cnt_q <= bit_cnt_q + 4'h1;
				tx_q      <= {tx_q[6:0], 1'b0};
			end
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = ack_drive_q | ((bus_q == lst_pkg::BUS_RDATA)
		&& (bit_cnt_q != lst_pkg::ACK_SLOT) && !tx_q[7]);

	// Timing chain: oscillator tick, integration clock, step
	logic        pwr, meas, wait_en, long_wait, restart;
	logic [5:0]  osc_cnt_q;
	logic [3:0]  int_div_q;
	logic [11:0] step_cnt_q;
	logic        osc_tick, int_tick, step_tick;
	assign pwr       = func_en_q[lst_pkg::PWR_BIT];
	assign meas      = func_en_q[lst_pkg::MEAS_BIT];
	assign wait_en   = func_en_q[lst_pkg::WAIT_EN_BIT];
	assign long_wait = cfg0_q[lst_pkg::LONG_WAIT_BIT];
	assign osc_tick  = pwr && (osc_cnt_q == 6'(OSC_DIV_P - 1));
	assign int_tick  = osc_tick && (int_div_q == 4'(lst_pkg::INT_CLK_DIV - 1));
	assign step_tick = int_tick && (step_cnt_q == 12'(STEP_CLKS_P - 1));

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			osc_cnt_q  <= 6'h00;
			int_div_q  <= 4'h0;
			step_cnt_q <= 12'h000;
		end
		else if (!pwr || restart)
		begin
			osc_cnt_q  <= 6'h00;
			int_div_q  <= 4'h0;
			step_cnt_q <= 12'h000;
		end
		else
		begin
			osc_cnt_q <= osc_tick ? 6'h00 : osc_cnt_q + 6'h01;
			if (osc_tick)
				int_div_q <= int_tick ? 4'h0 : int_div_q + 4'h1;
			if (int_tick)
				step_cnt_q <= step_tick ? 12'h000 : step_cnt_q + 12'h001;
		end
	end

	// Sequencer with one down counter shared by integration and wait
	lst_pkg::lst_seq_t seq_q;
	logic [7:0] down_q;
	logic [3:0] long_cnt_q;
	logic       done_q, wait_step;
	assign restart   = (seq_q == lst_pkg::SEQ_IDLE) && meas;
	assign wait_step = step_tick
		&& (!long_wait || long_cnt_q == 4'(lst_pkg::LONG_WAIT_FACTOR - 1));

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			long_cnt_q <= 4'h0;
		else if (seq_q != lst_pkg::SEQ_WAIT || wait_step)
			long_cnt_q <= 4'h0;
		else if (step_tick)
			long_cnt_q <= long_cnt_q + 4'h1;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			seq_q  <= lst_pkg::SEQ_SLEEP;
			down_q <= lst_pkg::STEP_ZERO;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (!pwr)
				seq_q <= lst_pkg::SEQ_SLEEP;
			else
			begin
				unique case (seq_q)
					lst_pkg::SEQ_SLEEP: seq_q <= lst_pkg::SEQ_IDLE;
					lst_pkg::SEQ_IDLE:
					begin
						if (meas)
						begin
							seq_q  <= lst_pkg::SEQ_MEASURE;
							down_q <= integ_q;
						end
					end
					lst_pkg::SEQ_MEASURE:
					begin
						if (!meas)
							seq_q <= lst_pkg::SEQ_IDLE;
						else if (step_tick)
						begin
							if (down_q != lst_pkg::STEP_ZERO)
								down_q <= down_q - 8'h01;
							else
							begin
								done_q <= 1'b1;
								if (wait_en)
								begin
									seq_q  <= lst_pkg::SEQ_WAIT;
									down_q <= wait_q;
								end
								else
									down_q <= integ_q;
							end
						end
					end
					lst_pkg::SEQ_WAIT:
					begin
						if (!meas)
							seq_q <= lst_pkg::SEQ_IDLE;
						else if (wait_step)
						begin
							if (down_q != lst_pkg::STEP_ZERO)
								down_q <= down_q - 8'h01;
							else
							begin
								seq_q  <= lst_pkg::SEQ_MEASURE;
								down_q <= integ_q;
							end
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			max_count_o <= 16'h0000;
		else
			max_count_o <= full_scale(integ_q);
	end

	assign status_o.osc_active  = pwr;
	assign status_o.conv_active = pwr;
	assign status_o.integrating = (seq_q == lst_pkg::SEQ_MEASURE);
	assign status_o.waiting     = (seq_q == lst_pkg::SEQ_WAIT);
	assign status_o.cycle_done  = done_q;
	assign status_o.state       = seq_q;

endmodule

// file: design/lst_pkg.sv
package lst_pkg;

	// Register offsets
	localparam logic [7:0] FUNC_EN_ADDR   = 8'h80;
	localparam logic [7:0] INTEG_ADDR     = 8'h81;
	localparam logic [7:0] WAIT_ADDR      = 8'h83;
	localparam logic [7:0] CFG0_ADDR      = 8'h8D;

	// Reset values, and the value read at unmapped offsets
	localparam logic [7:0] FUNC_EN_RST    = 8'h00;
	localparam logic [7:0] INTEG_RST      = 8'h00;
	localparam logic [7:0] WAIT_RST       = 8'h00;
	localparam logic [7:0] CFG0_RST       = 8'h80;
	localparam logic [7:0] RD_UNMAPPED    = 8'h00;

	// Field positions
	localparam int PWR_BIT                = 0;
	localparam int MEAS_BIT               = 1;
	localparam int WAIT_EN_BIT            = 3;
	localparam int LONG_WAIT_BIT          = 2;

	// Bus constants
	localparam logic [6:0] DEV_ADDR_DEF   = 7'h39;
	localparam logic [3:0] ACK_SLOT       = 4'h8;
	localparam logic [3:0] LAST_BIT       = 4'h7;
	localparam logic [7:0] PTR_STEP       = 8'h01;

	// Timing: clock, oscillator, division chain
	localparam int CLK_HZ                 = 250_000_000;
	localparam int OSC_HZ                 = 8_000_000;
	localparam int OSC_DIV                = CLK_HZ / OSC_HZ;
	localparam int INT_CLK_DIV            = 11;
	localparam int STEP_INT_CLKS          = 2048;
	localparam int LONG_WAIT_FACTOR       = 12;

	// Count bounds
	localparam logic [7:0]  STEP_ZERO     = 8'h00;
	localparam logic [16:0] COUNT_PER_STEP = 17'h00400;
	localparam logic [16:0] COUNT_SAT     = 17'h0FFFF;

	typedef enum logic [1:0] {
		SEQ_SLEEP,
		SEQ_IDLE,
		SEQ_MEASURE,
		SEQ_WAIT
	} lst_seq_t;

	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_DEV,
		BUS_REG,
		BUS_WDATA,
		BUS_RDATA
	} lst_bus_t;

	typedef struct packed {
		logic       osc_active;
		logic       conv_active;
		logic       integrating;
		logic       waiting;
		logic       cycle_done;
		lst_seq_t   state;
	} lst_status_t;

endpackage

// file: sim/lst_top_assertions.sv
`timescale 1ns/10ps
module lst_top_assertions #(
	parameter int OSC_DIV_P   = lst_pkg::OSC_DIV,      // Clocks per osc tick
	parameter int STEP_CLKS_P = lst_pkg::STEP_INT_CLKS // Int clocks per step
) (
	input wire logic                 clk_i,      // Clock
	input wire logic                 rst_i,      // Reset
	input wire logic                 scl_i,      // Serial clock
	input wire logic                 sda_i,      // Serial data
	input wire logic                 sda_o,      // Drive value
	input wire logic                 sda_oe_o,   // Drive enable
	input wire lst_pkg::lst_status_t status_o,   // Status
	input wire logic [15:0]          max_count_o // Full scale
);
	localparam int STEP = OSC_DIV_P * lst_pkg::INT_CLK_DIV * STEP_CLKS_P;
	lst_pkg::lst_seq_t prev_q;
	logic [19:0]       run_q;
	// Length of the state run just ended
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prev_q <= lst_pkg::SEQ_SLEEP;
			run_q  <= 20'h00000;
		end
		else
		begin
			prev_q <= status_o.state;
			run_q  <= (status_o.state == prev_q) ? run_q + 20'h00001 : 20'h00001;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	power_pair_a: assert property (status_o.osc_active == status_o.conv_active)
		else $error("osc and conv differ");
	meas_flag_a: assert property (status_o.integrating == (status_o.state == lst_pkg::SEQ_MEASURE))
		else $error("integrating flag wrong");
	wait_flag_a: assert property (status_o.waiting == (status_o.state == lst_pkg::SEQ_WAIT))
		else $error("waiting flag wrong");
	sleep_off_a: assert property (!status_o.osc_active |=> status_o.state == lst_pkg::SEQ_SLEEP)
		else $error("awake while unpowered");
	idle_on_a: assert property ($rose(status_o.osc_active) |=> status_o.state == lst_pkg::SEQ_IDLE)
		else $error("no idle after power");
	done_pulse_a: assert property (status_o.cycle_done |=> !status_o.cycle_done)
		else $error("done longer than one cycle");
	full_scale_a: assert property (!$past(rst_i) |-> max_count_o[9:0] == 10'h3FF)
		else $error("full scale low bits wrong");
	wait_order_a: assert property (status_o.state == lst_pkg::SEQ_WAIT |-> prev_q inside {lst_pkg::SEQ_MEASURE, lst_pkg::SEQ_WAIT})
		else $error("wait not after measure");
	meas_len_a: assert property (status_o.state == lst_pkg::SEQ_WAIT && prev_q == lst_pkg::SEQ_MEASURE |-> run_q % STEP == 0)
		else $error("measure not whole steps");
	wait_len_a: assert property (status_o.state == lst_pkg::SEQ_MEASURE && prev_q == lst_pkg::SEQ_WAIT |-> run_q % STEP == 0)
		else $error("wait not whole steps");
endmodule
bind lst_top lst_top_assertions #(.OSC_DIV_P(OSC_DIV_P), .STEP_CLKS_P(STEP_CLKS_P)) lst_top_assertions_i (
	.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .status_o(status_o), .max_count_o(max_count_o));

// file: sim/lst_host.sv
`timescale 1ns/10ps
module lst_host (
	input  wire logic clk_i,    // Clock
	input  wire logic sda_i,    // Wire level
	output logic      scl_o,    // Serial clock
	output logic      sda_low_o // Pull data low
);
	int nack_n = 0;
	initial
	begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic ph;
		repeat (10) @(posedge clk_i);
	endtask
	// Start is (0,1,1,0), stop is (1,1,0,1)
	task automatic edges(input logic s0, input logic c1, input logic s2, input logic c3);
		ph;
		sda_low_o <= s0;
		ph;
		scl_o <= c1;
		ph;
		sda_low_o <= s2;
		ph;
		scl_o <= c3;
	endtask
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			ph;
			sda_low_o <= !d[i];
			ph;
			scl_o <= 1'b1;
			ph;
			q[i] = sda_i;
			scl_o <= 1'b0;
		end
	endtask
	task automatic send(input logic [7:0] b);
		logic [8:0] q;
		xfer({b, 1'b1}, q);
		nack_n += int'(q[0]);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		edges(1'b0, 1'b1, 1'b1, 1'b0);
		send(8'h72);
		send(a);
		send(d);
		edges(1'b1, 1'b1, 1'b0, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] q;
		edges(1'b0, 1'b1, 1'b1, 1'b0);
		send(8'h72);
		send(a);
		edges(1'b0, 1'b1, 1'b1, 1'b0);
		send(8'h73);
		xfer(9'h1FF, q);
		d = q[8:1];
		edges(1'b1, 1'b1, 1'b0, 1'b1);
	endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
module tb;
	localparam int STEP = 2 * lst_pkg::INT_CLK_DIV * 4;
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	logic                 scl;
	logic                 sda_low;
	logic                 sda_o;
	logic                 sda_oe_o;
	wire logic            sda = !((sda_oe_o && !sda_o) || sda_low);
	lst_pkg::lst_status_t status_o;
	logic [15:0]          max_count_o;
	logic [15:0]          tot;
	logic [15:0]          ms;
	int                   errors = 0;
	int                   checked = 0;
	always #2 clk_i = !clk_i;
	lst_top #(.OSC_DIV_P(2), .STEP_CLKS_P(4)) lst_top_i (.clk_i(clk_i), .rst_i(rst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .status_o(status_o),
		.max_count_o(max_count_o));
	lst_host lst_host_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	task automatic fail(input string m);
		errors++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) fail($sformatf("byte %h, expected %h", g, e));
	endtask
	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) fail($sformatf("count %h, expected %h", g, e));
	endtask
	task automatic chkst(input lst_pkg::lst_seq_t g, input lst_pkg::lst_seq_t e);
		checked++;
		if (g !== e) fail($sformatf("state %0d, expected %0d", g, e));
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		lst_host_i.rd(a, d);
		chk8(d, e);
	endtask
	// Cycles from one done pulse to the next, and measuring cycles among them
	task automatic gap;
		tot = 16'h0000;
		ms  = 16'h0000;
		for (int i = 0; i < 5000 && status_o.cycle_done !== 1'b1; i++) @(negedge clk_i);
		do
		begin
			@(negedge clk_i);
			tot = tot + 16'h0001;
			ms  = ms + {15'h0000, status_o.integrating};
		end while (status_o.cycle_done !== 1'b1 && tot < 16'h2000);
	endtask
	task automatic t_reset;
		chkst(status_o.state, lst_pkg::SEQ_SLEEP);
		chk16(max_count_o, 16'h03FF);
		rchk(lst_pkg::FUNC_EN_ADDR, 8'h00);
		rchk(lst_pkg::INTEG_ADDR, 8'h00);
		rchk(lst_pkg::WAIT_ADDR, 8'h00);
		rchk(8'h82, lst_pkg::RD_UNMAPPED);
		$display("test reset done");
	endtask
	task automatic t_scale;
		logic [7:0]  v [6] = '{8'h01, 8'h3E, 8'h3F, 8'h80, 8'hFF, 8'h01};
		logic [15:0] e [6] = '{16'h07FF, 16'hFBFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h07FF};
		foreach (v[k])
		begin
			lst_host_i.wr(lst_pkg::INTEG_ADDR, v[k]);
			chk16(max_count_o, e[k]);
			rchk(lst_pkg::INTEG_ADDR, v[k]);
		end
		$display("test full scale done");
	endtask
	task automatic t_power;
		lst_host_i.wr(lst_pkg::FUNC_EN_ADDR, 8'hF5);
		rchk(lst_pkg::FUNC_EN_ADDR, 8'hF5);
		chkst(status_o.state, lst_pkg::SEQ_IDLE);
		chk8({6'h00, status_o.osc_active, status_o.conv_active}, 8'h03);
		$display("test power done");
	endtask
	task automatic t_run;
		lst_host_i.wr(lst_pkg::WAIT_ADDR, 8'h01);
		lst_host_i.wr(lst_pkg::FUNC_EN_ADDR, 8'h03);
		gap;
		chk16(tot, 16'(2 * STEP));
		chk16(ms, 16'(2 * STEP));
		lst_host_i.wr(lst_pkg::FUNC_EN_ADDR, 8'h0B);
		gap;
		chk16(tot, 16'(4 * STEP));
		chk16(ms, 16'(2 * STEP));
		lst_host_i.wr(lst_pkg::CFG0_ADDR, 8'h84);
		gap;
		chk16(tot, 16'((2 + 2 * lst_pkg::LONG_WAIT_FACTOR) * STEP));
		lst_host_i.wr(lst_pkg::FUNC_EN_ADDR, 8'h01);
		chkst(status_o.state, lst_pkg::SEQ_IDLE);
		lst_host_i.wr(lst_pkg::FUNC_EN_ADDR, 8'h00);
		chkst(status_o.state, lst_pkg::SEQ_SLEEP);
		chk16(16'(lst_host_i.nack_n), 16'h0000);
		$display("test run done");
	endtask
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(negedge clk_i);
		t_reset;
		t_scale;
		t_power;
		t_run;
		conclude;
	end
	initial
	begin
		repeat (60000) @(posedge clk_i);
		errors++;
		conclude;
	end
endmodule
